// ---- core/timer8_pkg.sv ----
// Constants, field layouts and reset values for the eight-bit waveform timer.
package timer8_pkg;

  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT   = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_FLAGS   = 3'h3;
  localparam logic [2:0] ADDR_PORT    = 3'h4;

  localparam int CTRL_FORCE_BIT = 7;
  localparam int CTRL_WGM0_BIT  = 6;
  localparam int CTRL_COM_HI    = 5;
  localparam int CTRL_COM_LO    = 4;
  localparam int CTRL_WGM1_BIT  = 3;
  localparam int CTRL_CS_HI     = 2;

  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_DIR_BIT = 1;

  localparam logic [1:0] WGM_NORMAL    = 2'h0;
  localparam logic [1:0] WGM_PHASE     = 2'h1;
  localparam logic [1:0] WGM_CLEAR     = 2'h2;
  localparam logic [1:0] WGM_FAST      = 2'h3;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [9:0] PRESC_MASK_1    = 10'h000;
  localparam logic [9:0] PRESC_MASK_8    = 10'h007;
  localparam logic [9:0] PRESC_MASK_64   = 10'h03f;
  localparam logic [9:0] PRESC_MASK_256  = 10'h0ff;
  localparam logic [9:0] PRESC_MASK_1024 = 10'h3ff;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [9:0] RESET_PRESC = 10'h000;

endpackage

// ---- core/timer8_waveform.sv ----
// Eight-bit timer with compare output unit, pin override and three counting modes.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module timer8_waveform (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            pin_o,
  output logic            pin_oe_o,
  output logic            overflow_flag_o,
  output logic            compare_flag_o,
  output logic            compare_output_state_o
);

  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic [1:0] compare_output_mode;
    logic [1:0] waveform_mode;
    logic [2:0] clock_select;
    logic [9:0] presc;
    logic       overflow_flag;
    logic       compare_flag;
    logic       compare_output_state;
    logic       match_block;
    logic       port_out;
    logic       pin_direction_bit;
    logic [7:0] rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic       tick;
  logic [9:0] presc_mask;
  logic       hit;
  logic       fast_mode;
  logic       cnt_wr;
  logic       force_now;
  logic       at_max;
  logic       ovf_set;
  logic       cmp_set;

  // The prescaler runs only while a clock is selected, so a stopped timer has no ticks.
  always_comb begin
    case (s_q.clock_select)
      3'h1:    presc_mask = timer8_pkg::PRESC_MASK_1;
      3'h2:    presc_mask = timer8_pkg::PRESC_MASK_8;
      3'h3:    presc_mask = timer8_pkg::PRESC_MASK_64;
      3'h4:    presc_mask = timer8_pkg::PRESC_MASK_256;
      default: presc_mask = timer8_pkg::PRESC_MASK_1024;
    endcase
  end

  assign tick = (s_q.clock_select != timer8_pkg::CS_STOP)
                && ((s_q.presc & presc_mask) == presc_mask)
                && (s_q.clock_select <= 3'h5);
  assign fast_mode = (s_q.waveform_mode == timer8_pkg::WGM_FAST);
  assign at_max    = (s_q.count_value == timer8_pkg::COUNT_MAX);
  // A counter equal to the compare value is a match unless a counter write blocks it.
  assign hit       = (s_q.count_value == s_q.compare_value) && !s_q.match_block;
  assign cnt_wr    = wr_i && (addr_i == timer8_pkg::ADDR_COUNT);
  assign force_now = wr_i && (addr_i == timer8_pkg::ADDR_CONTROL)
                     && wdata_i[timer8_pkg::CTRL_FORCE_BIT]
                     && !wdata_i[timer8_pkg::CTRL_WGM0_BIT];
  // Hardware set events, kept apart so that a same-cycle software clear always loses.
  assign ovf_set   = tick && at_max && (s_q.waveform_mode != timer8_pkg::WGM_PHASE);
  assign cmp_set   = tick && hit && (s_q.waveform_mode != timer8_pkg::WGM_PHASE);

  always_comb begin
    s_d       = s_q;
    s_d.rdata = timer8_pkg::RESET_BYTE;
    if (s_q.clock_select != timer8_pkg::CS_STOP) begin
      s_d.presc = s_q.presc + 10'h001;
    end
    if (tick) begin
      s_d.match_block = 1'b0;
      // Counting depends on the waveform mode, and in clear mode on the compare match as well.
      case (s_q.waveform_mode)
        timer8_pkg::WGM_NORMAL: begin
          s_d.count_value = s_q.count_value + 8'h01;
          if (at_max) begin
            s_d.overflow_flag = 1'b1;
          end
        end
        timer8_pkg::WGM_CLEAR: begin
          // A compare value below the count is missed until the counter wraps.
          if (hit) begin
            s_d.count_value = timer8_pkg::COUNT_BOTTOM;
          end else begin
            s_d.count_value = s_q.count_value + 8'h01;
          end
          if (at_max) begin
            s_d.overflow_flag = 1'b1;
          end
        end
        timer8_pkg::WGM_FAST: begin
          s_d.count_value = s_q.count_value + 8'h01;
          if (at_max) begin
            s_d.overflow_flag = 1'b1;
            s_d.compare_value = s_q.compare_buffer;
          end
        end
        default: begin
          s_d.count_value = s_q.count_value;
        end
      endcase
      if (hit && s_q.waveform_mode != timer8_pkg::WGM_PHASE) begin
        s_d.compare_flag = 1'b1;
      end
      // Match action; output mode zero leaves the state alone in every mode.
      if (s_q.waveform_mode != timer8_pkg::WGM_PHASE) begin
        case (s_q.compare_output_mode)
          timer8_pkg::COM_TOGGLE: begin
            if (hit) begin
              s_d.compare_output_state = !s_q.compare_output_state;
            end
          end
          timer8_pkg::COM_CLEAR: begin
            // At bottom the set wins, so compare 0xff holds a constant level.
            if (fast_mode && at_max) begin
              s_d.compare_output_state = 1'b1;
            end else if (hit) begin
              s_d.compare_output_state = 1'b0;
            end
          end
          timer8_pkg::COM_SET: begin
            if (fast_mode && at_max) begin
              s_d.compare_output_state = 1'b0;
            end else if (hit) begin
              s_d.compare_output_state = 1'b1;
            end
          end
          default: begin
            s_d.compare_output_state = s_q.compare_output_state;
          end
        endcase
      end
    end
    // The forced match uses the old output mode and touches neither flag nor counter.
    if (force_now && !fast_mode) begin
      case (s_q.compare_output_mode)
        timer8_pkg::COM_TOGGLE: s_d.compare_output_state = !s_q.compare_output_state;
        timer8_pkg::COM_CLEAR:  s_d.compare_output_state = 1'b0;
        timer8_pkg::COM_SET:    s_d.compare_output_state = 1'b1;
        default:                s_d.compare_output_state = s_q.compare_output_state;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        timer8_pkg::ADDR_CONTROL: begin
          s_d.compare_output_mode = wdata_i[timer8_pkg::CTRL_COM_HI:timer8_pkg::CTRL_COM_LO];
          s_d.waveform_mode = {wdata_i[timer8_pkg::CTRL_WGM1_BIT],
                               wdata_i[timer8_pkg::CTRL_WGM0_BIT]};
          s_d.clock_select = wdata_i[timer8_pkg::CTRL_CS_HI:0];
        end
        timer8_pkg::ADDR_COUNT: begin
          // A software write beats counting and blocks the next timer cycle's match.
          s_d.count_value = wdata_i;
          s_d.match_block = 1'b1;
        end
        timer8_pkg::ADDR_COMPARE: begin
          s_d.compare_buffer = wdata_i;
          if (s_q.waveform_mode[0] == 1'b0) begin
            s_d.compare_value = wdata_i;
          end
        end
        timer8_pkg::ADDR_FLAGS: begin
          // Writing one clears a flag, but a flag set in the same cycle survives.
          if (wdata_i[timer8_pkg::FLAG_OVF_BIT] && !ovf_set) begin
            s_d.overflow_flag = 1'b0;
          end
          if (wdata_i[timer8_pkg::FLAG_CMP_BIT] && !cmp_set) begin
            s_d.compare_flag = 1'b0;
          end
        end
        timer8_pkg::ADDR_PORT: begin
          s_d.port_out          = wdata_i[timer8_pkg::PORT_OUT_BIT];
          s_d.pin_direction_bit = wdata_i[timer8_pkg::PORT_DIR_BIT];
        end
        default: begin
          s_d.port_out = s_q.port_out;
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        timer8_pkg::ADDR_CONTROL: s_d.rdata = {1'b0, s_q.waveform_mode[0],
                                               s_q.compare_output_mode,
                                               s_q.waveform_mode[1], s_q.clock_select};
        timer8_pkg::ADDR_COUNT:   s_d.rdata = s_q.count_value;
        timer8_pkg::ADDR_COMPARE: s_d.rdata = s_q.compare_buffer;
        timer8_pkg::ADDR_FLAGS:   s_d.rdata = {6'h00, s_q.compare_flag, s_q.overflow_flag};
        timer8_pkg::ADDR_PORT:    s_d.rdata = {6'h00, s_q.pin_direction_bit, s_q.port_out};
        default:                  s_d.rdata = timer8_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Override depends on the output mode only, never on the waveform mode.
  assign pin_o = (s_q.compare_output_mode != timer8_pkg::COM_OFF) ?
                 s_q.compare_output_state : s_q.port_out;
  assign pin_oe_o               = s_q.pin_direction_bit;
  assign rdata_o                = s_q.rdata;
  assign overflow_flag_o        = s_q.overflow_flag;
  assign compare_flag_o         = s_q.compare_flag;
  assign compare_output_state_o = s_q.compare_output_state;

  property p_pin_override;
    @(posedge clk_sys_i) disable iff (rst_i)
      (s_q.compare_output_mode != timer8_pkg::COM_OFF) |-> (pin_o == s_q.compare_output_state);
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin not overridden");

  property p_pin_dir;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && addr_i == timer8_pkg::ADDR_PORT) |=> (pin_oe_o == $past(wdata_i[1]));
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");

  property p_normal_count;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && !wr_i && s_q.waveform_mode == timer8_pkg::WGM_NORMAL)
      |=> (s_q.count_value == $past(s_q.count_value) + 8'h01);
  endproperty
  a_normal_count: assert property (p_normal_count) else $error("normal count wrong");

  property p_normal_ovf;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && !wr_i && at_max && s_q.waveform_mode == timer8_pkg::WGM_NORMAL)
      |=> (overflow_flag_o && s_q.count_value == timer8_pkg::COUNT_BOTTOM);
  endproperty
  a_normal_ovf: assert property (p_normal_ovf) else $error("overflow not set");

  property p_clear_top;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && hit && !wr_i && s_q.waveform_mode == timer8_pkg::WGM_CLEAR)
      |=> (s_q.count_value == timer8_pkg::COUNT_BOTTOM && compare_flag_o);
  endproperty
  a_clear_top: assert property (p_clear_top) else $error("clear on match failed");

  property p_block;
    @(posedge clk_sys_i) disable iff (rst_i)
      cnt_wr |=> (s_q.match_block && !hit);
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_force_no_flag;
    @(posedge clk_sys_i) disable iff (rst_i)
      (force_now && !tick) |=> $stable(compare_flag_o) && $stable(s_q.count_value);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force touched flag");

  property p_mode_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      (s_q.compare_output_mode == timer8_pkg::COM_OFF) |=> $stable(compare_output_state_o);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("state moved in mode zero");

  property p_fast_set;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && at_max && fast_mode && s_q.compare_output_mode == timer8_pkg::COM_CLEAR)
      |=> compare_output_state_o;
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("bottom set missed");

  property p_fast_clr;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && at_max && fast_mode && s_q.compare_output_mode == timer8_pkg::COM_SET)
      |=> !compare_output_state_o;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("bottom clear missed");

  property p_fast_ovf;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && at_max && fast_mode) |=> overflow_flag_o;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("fast overflow missed");

  property p_fast_wrap;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && at_max && fast_mode && !cnt_wr)
      |=> (s_q.count_value == timer8_pkg::COUNT_BOTTOM);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap wrong");

  property p_reload;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && at_max && fast_mode) |=> (s_q.compare_value == $past(s_q.compare_buffer));
  endproperty
  a_reload: assert property (p_reload) else $error("compare reload wrong");

  property p_toggle;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && hit && s_q.waveform_mode == timer8_pkg::WGM_CLEAR
       && s_q.compare_output_mode == timer8_pkg::COM_TOGGLE)
      |=> (compare_output_state_o != $past(compare_output_state_o));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_clear_ovf;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && at_max && s_q.waveform_mode == timer8_pkg::WGM_CLEAR) |=> overflow_flag_o;
  endproperty
  a_clear_ovf: assert property (p_clear_ovf) else $error("wrap overflow missed");

  property p_cmp_set;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && hit && s_q.waveform_mode != timer8_pkg::WGM_PHASE) |=> compare_flag_o;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare flag missed");

  // Only software may drop the overflow flag; counting must never clear it.
  property p_ovf_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      (overflow_flag_o && !(wr_i && addr_i == timer8_pkg::ADDR_FLAGS
                            && wdata_i[timer8_pkg::FLAG_OVF_BIT])) |=> overflow_flag_o;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow cleared by count");

  property p_direct;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wr_i && addr_i == timer8_pkg::ADDR_COMPARE && !s_q.waveform_mode[0])
      |=> (s_q.compare_value == $past(wdata_i));
  endproperty
  a_direct: assert property (p_direct) else $error("direct compare write lost");

  property p_phase_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      (tick && !cnt_wr && s_q.waveform_mode == timer8_pkg::WGM_PHASE)
      |=> $stable(s_q.count_value);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase mode counted");

  property p_port_src;
    @(posedge clk_sys_i) disable iff (rst_i)
      (s_q.compare_output_mode == timer8_pkg::COM_OFF) |-> (pin_o == s_q.port_out);
  endproperty
  a_port_src: assert property (p_port_src) else $error("port value not on pin");

  property p_reset_state;
    @(posedge clk_sys_i) rst_i |-> !compare_output_state_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state not cleared");

  property p_force;
    @(posedge clk_sys_i) disable iff (rst_i)
      (force_now && !fast_mode && s_q.compare_output_mode[1])
      |=> (compare_output_state_o == $past(s_q.compare_output_mode[0]));
  endproperty
  a_force: assert property (p_force) else $error("forced action wrong");

  c_clear_match: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tick && hit && s_q.waveform_mode == timer8_pkg::WGM_CLEAR);
  c_fast_wrap: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tick && at_max && fast_mode);
  c_force: cover property (@(posedge clk_sys_i) disable iff (rst_i) force_now);
  c_slow_tick: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    tick && s_q.clock_select != 3'h1);
  c_flag_race: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    ovf_set && wr_i && addr_i == timer8_pkg::ADDR_FLAGS);

endmodule

// ---- test/pin_load.sv ----
// External load on the waveform pin, with a pull-down on the pad.
`timescale 1ns/1ps
module pin_load (
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      level_o
);
  // With the driver off the pad sinks through the pull-down, so no stale value survives.
  assign level_o = oe_i ? pin_i : 1'b0;
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the eight-bit waveform timer with a reference model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic       clk_sys_i;
  logic       rst_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       pin_o, pin_oe_o, overflow_flag_o, compare_flag_o, compare_output_state_o, level;
  int         n_errors, checks, cyc, seed_v, i, k, md, cm, kd, v, pe;
  int         cnt, cmp, bfr, ctl, ovf, cf, ocs, prt, blk, rdx, m, com, mt, nc, no, nf, ns, ncp;
  int         so, sf, ps, pm, tk;
  int         modes[4] = '{1, 0, 2, 3};
  int         dv[4] = '{8, 64, 256, 1024};

  timer8_waveform DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .overflow_flag_o(overflow_flag_o), .compare_flag_o(compare_flag_o),
    .compare_output_state_o(compare_output_state_o));
  pin_load load (.pin_i(pin_o), .oe_i(pin_oe_o), .level_o(level));

  always #25 clk_sys_i = ~clk_sys_i;

  // Output action of one match, shared by real and forced matches.
  function automatic int act(input int c, input int s);
    return (c == 1) ? int'(s == 0) : ((c >= 2) ? int'(c == 3) : s);
  endfunction

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      {cnt, cmp, bfr, ctl, ovf, cf, ocs, prt, blk, rdx, ps} = '0;
    end else begin
      m = ((ctl >> 6) & 1) | ((ctl >> 2) & 2);
      com = (ctl >> 4) & 3;
      rdx = 0;
      if (rd_i) begin
        case (addr_i)
          3'h0: rdx = ctl;
          3'h1: rdx = cnt;
          3'h2: rdx = bfr;
          3'h3: rdx = cf * 2 + ovf;
          3'h4: rdx = prt;
          default: rdx = 0;
        endcase
      end
      {nc, no, nf, ns, ncp, so, sf} = {cnt, ovf, cf, ocs, cmp, 32'd0, 32'd0};
      case (ctl & 7)
        1: pm = 0;
        2: pm = 7;
        3: pm = 63;
        4: pm = 255;
        default: pm = 1023;
      endcase
      tk = ((ctl & 7) != 0) && ((ctl & 7) <= 5) && ((ps & pm) == pm);
      if ((ctl & 7) != 0) ps = (ps + 1) & 1023;
      if (tk) begin
        mt = (cnt == cmp) && (blk == 0);
        blk = 0;
        if (m != 1) begin
          so = (cnt == 255);
          sf = mt;
          nc = (m == 2 && mt) ? 0 : (cnt + 1) & 255;
          if (m == 3 && com >= 2 && cnt == 255) ns = (com == 2);
          else if (mt && (m != 3 || com != 0)) ns = act(com, ocs);
          if (m == 3 && cnt == 255) ncp = bfr;
          if (so) no = 1;
          if (sf) nf = 1;
        end
      end
      if (wr_i) begin
        case (addr_i)
          3'h0: begin
            if (wdata_i[7] && !wdata_i[6] && m != 3) ns = act(com, ocs);
            ctl = wdata_i & 8'h7f;
          end
          3'h1: begin
            nc = wdata_i;
            blk = 1;
          end
          3'h2: begin
            bfr = wdata_i;
            if (m == 0 || m == 2) ncp = wdata_i;
          end
          3'h3: begin
            if (wdata_i[0] && !so) no = 0;
            if (wdata_i[1] && !sf) nf = 0;
          end
          3'h4: prt = wdata_i & 3;
          default: ;
        endcase
      end
      {cnt, ovf, cf, ocs, cmp} = {nc, no, nf, ns, ncp};
    end
  end

  always @(negedge clk_sys_i) begin
    pe = (((ctl >> 4) & 3) != 0) ? ocs : (prt & 1);
    `CHK("rdata", rdx, rdata_o)
    `CHK("state", ocs, compare_output_state_o)
    `CHK("ovf", ovf, overflow_flag_o)
    `CHK("cmpf", cf, compare_flag_o)
    `CHK("pin", pe, pin_o)
    `CHK("oe", (prt >> 1) & 1, pin_oe_o)
    `CHK("pad", (prt & 2) ? pe : 0, level)
  end

  task automatic bus(input int w, input int r, input int a, input int d);
    wr_i    <= 1'(w);
    rd_i    <= 1'(r);
    addr_i  <= 3'(a);
    wdata_i <= 8'(d);
    @(posedge clk_sys_i);
  endtask

  task automatic stop_test;
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // The ceiling leaves ample margin over the roughly eleven thousand cycles of stimulus.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {clk_sys_i, rst_i, addr_i, wdata_i, wr_i, rd_i} = 15'h2000;
    seed_v = $urandom(32'he76a);
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    bus(1, 0, 5, 8'hff);
    for (k = 0; k < 8; k++) bus(0, 1, k, 0);
    for (k = 0; k < 4; k++) begin
      bus(1, 0, 0, k << 4);
      bus(1, 0, 0, 8'h80 | (k << 4));
      bus(1, 0, 0, 8'h88 | (k << 4));
      bus(1, 0, 0, 8'h48 | (k << 4));
      bus(1, 0, 0, 8'h88 | (k << 4));
      bus(1, 0, 0, 8'hc8 | (k << 4));
    end
    // A count write while stopped must still hide the first match after start.
    bus(1, 0, 0, 8'h10);
    bus(1, 0, 2, 8'h05);
    bus(1, 0, 1, 8'h05);
    bus(1, 0, 0, 8'h11);
    for (md = 0; md < 4; md++) begin
      for (cm = 0; cm < 4; cm++) begin
        for (kd = 0; kd < 3; kd++) begin
          v = (kd == 0) ? 0 : ((kd == 1) ? 255 : $urandom % 256);
          bus(1, 0, 4, $urandom % 4);
          bus(1, 0, 0, ((modes[md] & 1) << 6) | (cm << 4) | ((modes[md] & 2) << 2) | 1);
          if (modes[md] != 1) bus(1, 0, 2, v);
          bus(1, 0, 1, $urandom % 256);
          for (i = 0; i < 160; i++) begin
            if (i == 60 && modes[md] != 1) bus(1, 0, 2, $urandom % 256);
            else if (i == 90) begin
              v = $urandom % 256;
              if (modes[md] != 1) bus(1, 0, 2, v);
              bus(1, 0, 1, v);
            end else if (i % 40 == 0) bus(1, 0, 3, $urandom % 4);
            else bus(0, int'($urandom % 3 == 0), $urandom % 8, 0);
          end
        end
      end
    end
    // Slower prescaler taps; reading the count every cycle shows each divided tick.
    for (k = 2; k <= 5; k++) begin
      bus(1, 0, 0, 8'h10 | k);
      bus(1, 0, 2, 8'hff);
      bus(1, 0, 1, 8'hfe);
      bus(1, 0, 3, 3);
      repeat (2 * dv[k - 2] + 4) bus(0, 1, 1, 0);
    end
    // A reset in mid-run must drop an output state that a forced set has raised.
    bus(1, 0, 0, 8'h30);
    bus(1, 0, 0, 8'hb0);
    bus(0, 0, 0, 0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    bus(0, 0, 0, 0);
    repeat (2) @(posedge clk_sys_i);
    stop_test();
  end
endmodule
